// ===== tile_status_pkg.sv
package tile_status_pkg;
   localparam logic [7:0] REG_TILE_CLOCK_CONTROL = 8'h02;
   localparam logic [7:0] REG_TILE_BOOT_STATUS = 8'h03;
   localparam logic [7:0] REG_SECURITY_COPY = 8'h05;
   localparam logic [7:0] REG_OSCILLATOR_CONTROL = 8'h06;
   localparam logic [7:0] REG_TILE_CELL_OSC_COUNT = 8'h07;
   localparam logic [7:0] REG_TILE_WIRE_OSC_COUNT = 8'h08;
   localparam logic [7:0] REG_PERIPH_CELL_OSC_COUNT = 8'h09;
   localparam logic [7:0] REG_PERIPH_WIRE_OSC_COUNT = 8'h0a;
   localparam logic [7:0] REG_DEBUG_SAVED_STATUS = 8'h10;
   localparam logic [7:0] REG_DEBUG_SAVED_PC = 8'h11;
   localparam logic [7:0] REG_DEBUG_SAVED_STACK = 8'h12;
   localparam logic [7:0] REG_DEBUG_READ_CORE_SELECT = 8'h13;
   localparam logic [7:0] REG_DEBUG_READ_REG_SELECT = 8'h14;
   localparam logic [7:0] REG_DEBUG_IRQ_CAUSE = 8'h15;
   localparam logic [7:0] REG_DEBUG_IRQ_INFO = 8'h16;
   localparam int DIVIDER_ENABLE_BIT = 4;
   localparam int DIVIDER_DYNAMIC_BIT = 5;
   localparam int OSC_TILE_BIT = 1;
   localparam int OSC_PERIPH_BIT = 0;
   localparam int TILE_NUMBER_LSB = 16;
   localparam int OTP_BOOT_BIT = 8;
   localparam int CAUSE_UNIT_LSB = 16;
   localparam int CAUSE_CORE_LSB = 8;
   localparam logic [31:0] CLOCK_CONTROL_RESET = 32'h0000_0000;
   localparam logic [1:0] OSC_CONTROL_RESET = 2'h0;
   localparam logic [2:0] CAUSE_RESET = 3'h0;
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_HOST = 3'h1;
   localparam logic [2:0] CAUSE_DEBUG_CALL = 3'h2;
   localparam logic [2:0] CAUSE_INSTR_BREAK = 3'h3;
   localparam logic [2:0] CAUSE_DATA_WATCH = 3'h4;
   localparam logic [2:0] CAUSE_RESOURCE_WATCH = 3'h5;
endpackage : tile_status_pkg

// ===== tile_status_debug_regs.sv
`timescale 1ns/1ns
// Function
// - control bit 4 high runs the tile clock through the divider; resets low
// - control bit 5 picks dynamic mode, slowing only while active cores pause
// - boot status bits 23:16 report this tile's switch number, read-only
// - boot status bit 8 reads one when boot from OTP is enabled
// - boot status bits 7:0 show the sampled boot-mode pin levels
// - security copy register shows the 32-bit OTP security word, read-only
// - oscillator control bit 1 runs tile oscillators, bit 0 peripheral ones
// - registers 0x07 to 0x0A return the four 16-bit oscillator counts
// - oscillator counts are kept across system reset
// - oscillators run asynchronously to the tile clock, giving random bits
// - debugger entry captures the saved status word into entry 0x10
// - debugger entry captures saved pc into 0x11 and stack into 0x12
// - first fetch operand holds the logical core number in bits 7:0
// - second fetch operand holds the core register index in bits 4:0
// - irq cause bits 2:0 record the debug interrupt cause, reset zero
// - cause bits 17:16 hold the lowest triggering unit number
// - cause bits 15:8 hold the causing core number, else zero
// - irq info captures watch address or triggering resource identifier
module tile_status_debug_regs #(
   parameter int CORE_WIDTH = 8,
   parameter int UNITS = 4
) (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic CLOCK_ENABLE,
   input wire logic [7:0] REG_NUMBER,
   input wire logic REG_WRITE,
   input wire logic REG_READ,
   input wire logic [31:0] REG_WRITE_DATA,
   output logic [31:0] REG_READ_DATA,
   output logic REG_READ_VALID,
   input wire logic DEBUG_MODE,
   input wire logic ALL_CORES_PAUSED,
   output logic DIVIDER_ACTIVE,
   input wire logic [7:0] TILE_NUMBER,
   input wire logic OTP_BOOT_ENABLE,
   input wire logic [7:0] BOOT_MODE_PIN,
   input wire logic [31:0] OTP_SECURITY_WORD,
   output logic TILE_OSC_RUN,
   output logic PERIPH_OSC_RUN,
   input wire logic [15:0] TILE_CELL_COUNT,
   input wire logic [15:0] TILE_WIRE_COUNT,
   input wire logic [15:0] PERIPH_CELL_COUNT,
   input wire logic [15:0] PERIPH_WIRE_COUNT,
   input wire logic DEBUG_ENTRY,
   input wire logic [2:0] ENTRY_CAUSE,
   input wire logic ENTRY_BY_CORE,
   input wire logic [CORE_WIDTH-1:0] ENTRY_CORE,
   input wire logic [UNITS-1:0] ENTRY_UNIT_HITS,
   input wire logic [31:0] ENTRY_INFO,
   input wire logic [31:0] SAVED_STATUS_WORD,
   input wire logic [31:0] SAVED_PROGRAM_COUNTER,
   input wire logic [31:0] SAVED_STACK_POINTER,
   output logic [7:0] FETCH_CORE,
   output logic [4:0] FETCH_REGISTER
);
   // pin and foreign-domain inputs: two-stage synchronisers
   logic [7:0] tile_meta_r;
   logic [7:0] tile_sync_r;
   logic otp_meta_r;
   logic otp_sync_r;
   logic [7:0] mode_meta_r;
   logic [7:0] mode_sync_r;
   logic [31:0] sec_meta_r;
   logic [31:0] sec_sync_r;
   logic [63:0] cnt_meta_r;
   logic [63:0] cnt_sync_r;
   logic [63:0] cnt_raw;

   logic [1:0] divider_ctl_r;
   logic [1:0] divider_ctl_nxt;
   logic [1:0] divider_reset;
   logic [1:0] osc_ctl_r;
   logic [1:0] osc_ctl_nxt;
   logic [31:0] saved_status_r;
   logic [31:0] saved_status_nxt;
   logic [31:0] saved_pc_r;
   logic [31:0] saved_pc_nxt;
   logic [31:0] saved_stack_r;
   logic [31:0] saved_stack_nxt;
   logic [7:0] fetch_core_r;
   logic [7:0] fetch_core_nxt;
   logic [4:0] fetch_reg_r;
   logic [4:0] fetch_reg_nxt;
   logic [2:0] cause_r;
   logic [2:0] cause_nxt;
   logic [7:0] cause_core_r;
   logic [7:0] cause_core_nxt;
   logic [1:0] cause_unit_r;
   logic [1:0] cause_unit_nxt;
   logic [31:0] info_r;
   logic [31:0] info_nxt;
   logic [31:0] read_data_r;
   logic read_valid_r;

   logic [1:0] lowest_unit;
   logic [7:0] entry_core8;
   logic unit_cause;
   logic info_cause;
   logic dbg_write;
   logic wr_clock_ctl;
   logic wr_osc_ctl;
   logic wr_pc;
   logic wr_stack;
   logic wr_core;
   logic wr_reg;
   logic wr_cause;
   logic wr_info;
   logic [31:0] read_mux;

   assign cnt_raw = {PERIPH_WIRE_COUNT, PERIPH_CELL_COUNT,
                     TILE_WIRE_COUNT, TILE_CELL_COUNT};

   // counts are sampled without reset so they survive system reset
   always_ff @(posedge CLOCK) begin
      if (CLOCK_ENABLE) begin
         cnt_meta_r <= cnt_raw;
         cnt_sync_r <= cnt_meta_r;
      end
   end

   // pin levels settle once after power-up, so no reset is needed
   always_ff @(posedge CLOCK) begin
      if (CLOCK_ENABLE) begin
         tile_meta_r <= TILE_NUMBER;
         tile_sync_r <= tile_meta_r;
         otp_meta_r <= OTP_BOOT_ENABLE;
         otp_sync_r <= otp_meta_r;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (CLOCK_ENABLE) begin
         mode_meta_r <= BOOT_MODE_PIN;
         mode_sync_r <= mode_meta_r;
         sec_meta_r <= OTP_SECURITY_WORD;
         sec_sync_r <= sec_meta_r;
      end
   end

   // lowest-numbered triggering unit wins
   always_comb begin
      lowest_unit = 2'h0;
      for (int i = UNITS - 1; i >= 0; i--) begin
         if (ENTRY_UNIT_HITS[i]) begin
            lowest_unit = 2'(i);
         end
      end
   end

   assign entry_core8 = ENTRY_BY_CORE ? 8'(ENTRY_CORE) : 8'h00;

   assign dbg_write = REG_WRITE && DEBUG_MODE;
   assign wr_clock_ctl = REG_WRITE &&
      REG_NUMBER == tile_status_pkg::REG_TILE_CLOCK_CONTROL;
   assign wr_osc_ctl = REG_WRITE &&
      REG_NUMBER == tile_status_pkg::REG_OSCILLATOR_CONTROL;
   assign wr_pc = dbg_write &&
      REG_NUMBER == tile_status_pkg::REG_DEBUG_SAVED_PC;
   assign wr_stack = dbg_write &&
      REG_NUMBER == tile_status_pkg::REG_DEBUG_SAVED_STACK;
   assign wr_core = dbg_write &&
      REG_NUMBER == tile_status_pkg::REG_DEBUG_READ_CORE_SELECT;
   assign wr_reg = dbg_write &&
      REG_NUMBER == tile_status_pkg::REG_DEBUG_READ_REG_SELECT;
   assign wr_cause = dbg_write &&
      REG_NUMBER == tile_status_pkg::REG_DEBUG_IRQ_CAUSE;
   assign wr_info = dbg_write &&
      REG_NUMBER == tile_status_pkg::REG_DEBUG_IRQ_INFO;

   // control registers
   assign divider_reset = {
      tile_status_pkg::CLOCK_CONTROL_RESET[
         tile_status_pkg::DIVIDER_DYNAMIC_BIT],
      tile_status_pkg::CLOCK_CONTROL_RESET[
         tile_status_pkg::DIVIDER_ENABLE_BIT]};
   assign divider_ctl_nxt = wr_clock_ctl ? {
      REG_WRITE_DATA[tile_status_pkg::DIVIDER_DYNAMIC_BIT],
      REG_WRITE_DATA[tile_status_pkg::DIVIDER_ENABLE_BIT]} : divider_ctl_r;
   assign osc_ctl_nxt = wr_osc_ctl ? {
      REG_WRITE_DATA[tile_status_pkg::OSC_TILE_BIT],
      REG_WRITE_DATA[tile_status_pkg::OSC_PERIPH_BIT]} : osc_ctl_r;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         divider_ctl_r <= divider_reset;
      end else if (CLOCK_ENABLE) begin
         divider_ctl_r <= divider_ctl_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         osc_ctl_r <= tile_status_pkg::OSC_CONTROL_RESET;
      end else if (CLOCK_ENABLE) begin
         osc_ctl_r <= osc_ctl_nxt;
      end
   end

   // debug capture: entry wins over a same-cycle software write
   assign unit_cause = ENTRY_CAUSE == tile_status_pkg::CAUSE_INSTR_BREAK ||
      ENTRY_CAUSE == tile_status_pkg::CAUSE_DATA_WATCH ||
      ENTRY_CAUSE == tile_status_pkg::CAUSE_RESOURCE_WATCH;
   assign info_cause = ENTRY_CAUSE == tile_status_pkg::CAUSE_DATA_WATCH ||
      ENTRY_CAUSE == tile_status_pkg::CAUSE_RESOURCE_WATCH;
   assign saved_status_nxt = DEBUG_ENTRY ? SAVED_STATUS_WORD :
      saved_status_r;
   assign saved_pc_nxt = DEBUG_ENTRY ? SAVED_PROGRAM_COUNTER :
      wr_pc ? REG_WRITE_DATA : saved_pc_r;
   assign saved_stack_nxt = DEBUG_ENTRY ? SAVED_STACK_POINTER :
      wr_stack ? REG_WRITE_DATA : saved_stack_r;
   assign cause_nxt = DEBUG_ENTRY ? ENTRY_CAUSE :
      wr_cause ? REG_WRITE_DATA[2:0] : cause_r;
   assign cause_core_nxt = DEBUG_ENTRY ? entry_core8 :
      wr_cause ? REG_WRITE_DATA[tile_status_pkg::CAUSE_CORE_LSB +: 8] :
      cause_core_r;
   assign cause_unit_nxt = DEBUG_ENTRY ?
      (unit_cause ? lowest_unit : 2'h0) :
      wr_cause ? REG_WRITE_DATA[tile_status_pkg::CAUSE_UNIT_LSB +: 2] :
      cause_unit_r;
   assign info_nxt = DEBUG_ENTRY ?
      (info_cause ? ENTRY_INFO : info_r) :
      wr_info ? REG_WRITE_DATA : info_r;
   assign fetch_core_nxt = wr_core ? REG_WRITE_DATA[7:0] :
      fetch_core_r;
   assign fetch_reg_nxt = wr_reg ? REG_WRITE_DATA[4:0] :
      fetch_reg_r;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         saved_status_r <= 32'h0000_0000;
      end else if (CLOCK_ENABLE) begin
         saved_status_r <= saved_status_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         saved_pc_r <= 32'h0000_0000;
      end else if (CLOCK_ENABLE) begin
         saved_pc_r <= saved_pc_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         saved_stack_r <= 32'h0000_0000;
      end else if (CLOCK_ENABLE) begin
         saved_stack_r <= saved_stack_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         fetch_core_r <= 8'h00;
      end else if (CLOCK_ENABLE) begin
         fetch_core_r <= fetch_core_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         fetch_reg_r <= 5'h00;
      end else if (CLOCK_ENABLE) begin
         fetch_reg_r <= fetch_reg_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         cause_r <= tile_status_pkg::CAUSE_RESET;
      end else if (CLOCK_ENABLE) begin
         cause_r <= cause_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         cause_core_r <= 8'h00;
      end else if (CLOCK_ENABLE) begin
         cause_core_r <= cause_core_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         cause_unit_r <= 2'h0;
      end else if (CLOCK_ENABLE) begin
         cause_unit_r <= cause_unit_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         info_r <= 32'h0000_0000;
      end else if (CLOCK_ENABLE) begin
         info_r <= info_nxt;
      end
   end

   // read decode; unmapped numbers and reserved bits read zero
   always_comb begin
      read_mux = 32'h0000_0000;
      case (REG_NUMBER)
         tile_status_pkg::REG_TILE_CLOCK_CONTROL: begin
            read_mux[tile_status_pkg::DIVIDER_ENABLE_BIT] = divider_ctl_r[0];
            read_mux[tile_status_pkg::DIVIDER_DYNAMIC_BIT] = divider_ctl_r[1];
         end
         tile_status_pkg::REG_TILE_BOOT_STATUS: begin
            read_mux[23:16] = tile_sync_r;
            read_mux[tile_status_pkg::OTP_BOOT_BIT] = otp_sync_r;
            read_mux[7:0] = mode_sync_r;
         end
         tile_status_pkg::REG_SECURITY_COPY: begin
            read_mux = sec_sync_r;
         end
         tile_status_pkg::REG_OSCILLATOR_CONTROL: begin
            read_mux[1:0] = osc_ctl_r;
         end
         tile_status_pkg::REG_TILE_CELL_OSC_COUNT: begin
            read_mux[15:0] = cnt_sync_r[15:0];
         end
         tile_status_pkg::REG_TILE_WIRE_OSC_COUNT: begin
            read_mux[15:0] = cnt_sync_r[31:16];
         end
         tile_status_pkg::REG_PERIPH_CELL_OSC_COUNT: begin
            read_mux[15:0] = cnt_sync_r[47:32];
         end
         tile_status_pkg::REG_PERIPH_WIRE_OSC_COUNT: begin
            read_mux[15:0] = cnt_sync_r[63:48];
         end
         tile_status_pkg::REG_DEBUG_SAVED_STATUS: begin
            read_mux = saved_status_r;
         end
         tile_status_pkg::REG_DEBUG_SAVED_PC: begin
            read_mux = saved_pc_r;
         end
         tile_status_pkg::REG_DEBUG_SAVED_STACK: begin
            read_mux = saved_stack_r;
         end
         tile_status_pkg::REG_DEBUG_READ_CORE_SELECT: begin
            read_mux[7:0] = fetch_core_r;
         end
         tile_status_pkg::REG_DEBUG_READ_REG_SELECT: begin
            read_mux[4:0] = fetch_reg_r;
         end
         tile_status_pkg::REG_DEBUG_IRQ_CAUSE: begin
            read_mux[17:16] = cause_unit_r;
            read_mux[15:8] = cause_core_r;
            read_mux[2:0] = cause_r;
         end
         tile_status_pkg::REG_DEBUG_IRQ_INFO: begin
            read_mux = info_r;
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   // one word per read, answered the next cycle
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         read_data_r <= 32'h0000_0000;
         read_valid_r <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         read_valid_r <= REG_READ;
         if (REG_READ) begin
            read_data_r <= read_mux;
         end
      end
   end

   assign REG_READ_DATA = read_data_r;
   assign REG_READ_VALID = read_valid_r;
   assign DIVIDER_ACTIVE = divider_ctl_r[0] &&
      (!divider_ctl_r[1] || ALL_CORES_PAUSED);
   assign TILE_OSC_RUN = osc_ctl_r[1];
   assign PERIPH_OSC_RUN = osc_ctl_r[0];
   assign FETCH_CORE = fetch_core_r;
   assign FETCH_REGISTER = fetch_reg_r;
endmodule : tile_status_debug_regs

// ===== tile_status_debug_regs_properties.sv
`timescale 1ns/1ns
module tile_status_checker (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic CLOCK_ENABLE,
   input wire logic [7:0] REG_NUMBER,
   input wire logic REG_WRITE,
   input wire logic REG_READ,
   input wire logic [31:0] REG_WRITE_DATA,
   input wire logic [31:0] REG_READ_DATA,
   input wire logic REG_READ_VALID,
   input wire logic DEBUG_MODE,
   input wire logic ALL_CORES_PAUSED,
   input wire logic DIVIDER_ACTIVE,
   input wire logic TILE_OSC_RUN,
   input wire logic PERIPH_OSC_RUN,
   input wire logic DEBUG_ENTRY,
   input wire logic [7:0] FETCH_CORE,
   input wire logic [4:0] FETCH_REGISTER
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   wire logic rd = REG_READ && CLOCK_ENABLE;
   wire logic wr = REG_WRITE && CLOCK_ENABLE;
   wire logic dwr = wr && DEBUG_MODE;
   property p_valid; rd |=> REG_READ_VALID; endproperty
   a_valid: assert property (p_valid) else $error("no valid");
   property p_quiet; CLOCK_ENABLE && !REG_READ |=> !REG_READ_VALID &&
      $stable(REG_READ_DATA); endproperty
   a_quiet: assert property (p_quiet) else $error("stray read");
   property p_div; wr && REG_NUMBER == 8'h02 |=> DIVIDER_ACTIVE ==
      ($past(REG_WRITE_DATA[4]) && (!$past(REG_WRITE_DATA[5]) ||
      ALL_CORES_PAUSED)); endproperty
   a_div: assert property (p_div) else $error("bad divider");
   property p_osc; wr && REG_NUMBER == 8'h06 |=>
      {TILE_OSC_RUN, PERIPH_OSC_RUN} == $past(REG_WRITE_DATA[1:0]);
   endproperty
   a_osc: assert property (p_osc) else $error("bad osc run");
   property p_core; dwr && REG_NUMBER == 8'h13 |=>
      FETCH_CORE == $past(REG_WRITE_DATA[7:0]); endproperty
   a_core: assert property (p_core) else $error("bad core");
   property p_reg; dwr && REG_NUMBER == 8'h14 |=>
      FETCH_REGISTER == $past(REG_WRITE_DATA[4:0]); endproperty
   a_reg: assert property (p_reg) else $error("bad reg");
   property p_lock; !(dwr && REG_NUMBER inside {8'h13, 8'h14}) |=>
      $stable(FETCH_CORE) && $stable(FETCH_REGISTER); endproperty
   a_lock: assert property (p_lock) else $error("fetch moved");
   property p_rd_osc; rd && REG_NUMBER == 8'h06 |=> REG_READ_DATA ==
      {30'h0, $past(TILE_OSC_RUN), $past(PERIPH_OSC_RUN)}; endproperty
   a_rd_osc: assert property (p_rd_osc) else $error("osc read");
   property p_rsv; rd && REG_NUMBER == 8'h02 |=>
      (REG_READ_DATA & 32'hffff_ffcf) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   c_entry: cover property (DEBUG_ENTRY && CLOCK_ENABLE);
   c_div: cover property (DIVIDER_ACTIVE && ALL_CORES_PAUSED);
   c_reads: cover property (rd ##2 rd);
endmodule : tile_status_checker
bind tile_status_debug_regs tile_status_checker chk_u (.*);

// ===== tile_osc_model.sv
`timescale 1ns/1ns
module tile_osc_model (
   input wire logic tile_run,
   input wire logic periph_run,
   output logic [63:0] counts
);
   logic osc_clk = 1'b0;
   logic [63:0] count_r = 64'h0123_4567_89ab_cdef;
   assign counts = count_r;
   always #3 osc_clk = ~osc_clk;
   // counts have no reset, so a tile reset leaves them alone
   always @(posedge osc_clk) begin
      for (int i = 0; i < 4; i++) begin
         if ((i < 2) ? tile_run : periph_run) begin
            count_r[i*16 +: 16] <= count_r[i*16 +: 16] + 16'(i + 1);
         end
      end
   end
endmodule : tile_osc_model

// ===== tile_status_debug_regs_tb_top.sv
`timescale 1ns/1ns
module tile_status_debug_regs_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce, wr, rd, dbg, paused, entry, by_core, valid, div, trun, prun, otp;
   logic [7:0] num, core, fcore;
   logic [3:0] hits;
   logic [4:0] freg;
   logic [2:0] cause;
   logic [31:0] wdata, info, sw, pc, sp, rdata, info_exp;
   logic [63:0] cnt, seen;
   int n_errors = 0;
   int checked = 0;
   always #2 clk = ~clk;
   tile_osc_model osc_u (.tile_run(trun), .periph_run(prun), .counts(cnt));
   tile_status_debug_regs dut_u (.CLOCK(clk), .RESET(rst),
      .CLOCK_ENABLE(ce), .REG_NUMBER(num), .REG_WRITE(wr), .REG_READ(rd),
      .REG_WRITE_DATA(wdata), .REG_READ_DATA(rdata), .REG_READ_VALID(valid),
      .DEBUG_MODE(dbg), .ALL_CORES_PAUSED(paused), .DIVIDER_ACTIVE(div),
      .TILE_NUMBER(8'h5a), .OTP_BOOT_ENABLE(otp), .BOOT_MODE_PIN(8'ha5),
      .OTP_SECURITY_WORD(32'h1357_9bdf), .TILE_OSC_RUN(trun),
      .PERIPH_OSC_RUN(prun), .TILE_CELL_COUNT(cnt[15:0]),
      .TILE_WIRE_COUNT(cnt[31:16]), .PERIPH_CELL_COUNT(cnt[47:32]),
      .PERIPH_WIRE_COUNT(cnt[63:48]), .DEBUG_ENTRY(entry),
      .ENTRY_CAUSE(cause), .ENTRY_BY_CORE(by_core), .ENTRY_CORE(core),
      .ENTRY_UNIT_HITS(hits), .ENTRY_INFO(info), .SAVED_STATUS_WORD(sw),
      .SAVED_PROGRAM_COUNTER(pc), .SAVED_STACK_POINTER(sp),
      .FETCH_CORE(fcore), .FETCH_REGISTER(freg));
   task automatic wrap_up;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wrt(input logic [7:0] n, input logic [31:0] d);
      @(negedge clk);
      num = n;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wrt
   task automatic rdc(input string what, input logic [7:0] n,
                      input logic [31:0] exp);
      @(negedge clk);
      num = n;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("read valid", 32'h1, {31'h0, valid});
      chk(what, exp, rdata);
   endtask : rdc
   initial #200000 begin
      n_errors++;
      wrap_up;
   end
   initial begin
      {ce, otp, wr, rd, dbg, paused, entry, by_core} = 8'hc0;
      {num, core, cause, wdata, info, sw, pc, sp, info_exp, hits} = '0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      rdc("control", 8'h02, 32'h0);
      rdc("osc control", 8'h06, 32'h0);
      rdc("cause", 8'h15, 32'h0);
      wrt(8'h03, 32'h0);
      rdc("boot status", 8'h03, 32'h005a_01a5);
      otp = 1'b0;
      repeat (3) @(negedge clk);
      rdc("boot status", 8'h03, 32'h005a_00a5);
      rdc("security", 8'h05, 32'h1357_9bdf);
      rdc("unmapped", 8'h04, 32'h0);
      wrt(8'h02, 32'hffff_ffff);
      rdc("control", 8'h02, 32'h0000_0030);
      chk("divider", 32'h0, {31'h0, div});
      paused = 1'b1;
      #1 chk("divider", 32'h1, {31'h0, div});
      @(negedge clk);
      paused = 1'b0;
      wrt(8'h02, 32'h10);
      chk("divider", 32'h1, {31'h0, div});
      wrt(8'h06, 32'h3);
      chk("osc run", 32'h3, {30'h0, trun, prun});
      repeat (50) @(negedge clk);
      wrt(8'h06, 32'h1);
      chk("osc run", 32'h1, {30'h0, trun, prun});
      repeat (50) @(negedge clk);
      wrt(8'h06, 32'h0);
      repeat (4) @(negedge clk);
      seen = cnt;
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) begin
            rdc("osc count", 8'h07 + 8'(i),
               {16'h0, seen[i*16 +: 16]});
         end
         rst = 1'b1;
         @(negedge clk);
         rst = 1'b0;
      end
      wrt(8'h13, 32'hffff_ffff);
      rdc("core select", 8'h13, 32'h0);
      dbg = 1'b1;
      wrt(8'h13, 32'hffff_ffff);
      rdc("core select", 8'h13, 32'h0000_00ff);
      chk("fetch core", 32'hff, {24'h0, fcore});
      wrt(8'h14, 32'hffff_ffff);
      chk("fetch reg", 32'h1f, {27'h0, freg});
      ce = 1'b0;
      wrt(8'h14, 32'h0);
      ce = 1'b1;
      rdc("reg select", 8'h14, 32'h0000_001f);
      for (int c = 1; c < 6; c++) begin
         @(negedge clk);
         cause = 3'(c);
         hits = 4'(c << 1);
         by_core = c[0];
         core = 8'h40 + 8'(c);
         info = 32'hc0de_0000 + 32'(c);
         sw = 32'h5000_0000 + 32'(c);
         pc = ~sw;
         sp = {sw[15:0], sw[31:16]};
         entry = 1'b1;
         @(negedge clk);
         entry = 1'b0;
         if (c > 3) info_exp = info;
         rdc("cause", 8'h15, {14'h0, ((c < 3) ? 2'h0 : (c == 4) ? 2'h3 : 2'h1),
            (by_core ? core : 8'h0), 5'h0, cause});
         rdc("info", 8'h16, info_exp);
         rdc("saved status", 8'h10, sw);
         rdc("saved pc", 8'h11, pc);
         rdc("saved stack", 8'h12, sp);
      end
      wrt(8'h11, 32'h0bad_cafe);
      rdc("saved pc", 8'h11, 32'h0bad_cafe);
      wrap_up;
   end
endmodule : tile_status_debug_regs_tb_top
